// [logic/lddcl_params.svh]
`ifndef LDDCL_PARAMS_SVH
`define LDDCL_PARAMS_SVH

// System clock
`define LDDCL_CLK_PERIOD_NS 100

// Fault persistence, in dimming pulses
`define LDDCL_FAULT_PULSES 9'h1FC

// Fault patterns, leftmost bit sent first
`define LDDCL_PAT_OV_CH1 4'h1
`define LDDCL_PAT_OV_CH2 4'h3
`define LDDCL_PAT_UV_CH1 4'h5
`define LDDCL_PAT_UV_CH2 4'h7

// Command patterns and their lengths
`define LDDCL_CMD_NORMAL_BITS 12'hF77
`define LDDCL_CMD_NORMAL_LEN 5'h0C
`define LDDCL_CMD_DOWN20_BITS 16'hF111
`define LDDCL_CMD_DOWN20_LEN 5'h10
`define LDDCL_CMD_DOWN40_BITS 12'hF33
`define LDDCL_CMD_DOWN40_LEN 5'h0C
`define LDDCL_CMD_CH1OFF_BITS 14'h3D55
`define LDDCL_CMD_CH1OFF_LEN 5'h0E

// Host link timing
`define LDDCL_DIM_HALF 5'h08
`define LDDCL_EN_PULSE_NS 200
`define LDDCL_EN_PULSE_CYC ((`LDDCL_EN_PULSE_NS + `LDDCL_CLK_PERIOD_NS - 1) / `LDDCL_CLK_PERIOD_NS)

`endif

// [logic/lddcl_pkg.sv]
package lddcl_pkg;

	typedef enum logic [1:0] {
		lddcl_freq_normal,
		lddcl_freq_down20,
		lddcl_freq_down40
	} lddcl_freq_type;

	typedef enum logic [1:0] {
		lddcl_cmd_normal,
		lddcl_cmd_down20,
		lddcl_cmd_down40,
		lddcl_cmd_ch1_off
	} lddcl_cmd_type;

endpackage

// [logic/lddcl_if.sv]
interface lddcl_if;
	logic dim_ch1;
	logic dim_ch2;
	logic en;
	logic pullup_en;
	logic dev_diag_out;
	logic dev_diag_oe;
	logic host_diag_out;
	logic host_diag_oe;
	wire logic diag_line;

	// Open-drain wired-AND; without the host pull-up the line sits at zero
	assign diag_line = pullup_en & ~((dev_diag_oe & ~dev_diag_out) | (host_diag_oe & ~host_diag_out));

	modport dev (
		input dim_ch1,
		input dim_ch2,
		input en,
		input diag_line,
		output dev_diag_out,
		output dev_diag_oe
	);

	modport host (
		output dim_ch1,
		output dim_ch2,
		output en,
		output pullup_en,
		output host_diag_out,
		output host_diag_oe,
		input diag_line
	);
endinterface

// [logic/lddcl_dev_end.sv]
`include "lddcl_params.svh"

module lddcl_dev_end
	import lddcl_pkg::*;
(
	// System
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Link
	lddcl_if.dev link,
	// Analog comparator levels
	input wire logic pg_cmp_in,
	input wire logic ot_cmp_in,
	input wire logic [1:0] ov_cmp_in,
	input wire logic [1:0] uv_cmp_in,
	input wire logic headroom_max_in,
	// Converter controls and status
	output lddcl_freq_type switch_freq_out,
	output logic sink_en_ch1_out,
	output logic power_good_out,
	output logic over_temp_out,
	output logic fault_valid_out,
	output logic [3:0] fault_code_out
);

	////////////////////////////////////////////////////////////////////////////
	// System domain: input synchronisers

	logic [9:0] in_meta;
	logic [9:0] in_sync;
	wire [9:0] in_raw = {link.dim_ch2, link.dim_ch1, headroom_max_in, uv_cmp_in, ov_cmp_in, link.en,
		ot_cmp_in, pg_cmp_in};
	wire s_pg = in_sync[0];
	wire s_ot = in_sync[1];
	wire s_en = in_sync[2];
	wire [1:0] s_ov = in_sync[4:3];
	wire [1:0] s_uv = in_sync[6:5];
	wire s_hr = in_sync[7];
	wire [1:0] s_dim = in_sync[9:8];

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			in_meta <= 10'h000;
			in_sync <= 10'h000;
		end
		else
		begin
			in_meta <= in_raw;
			in_sync <= in_meta;
		end
	end

	// Only the fault detectors are stopped; conversion has no hook here
	// counters held in clear
	wire hold_clr = ~s_en | s_ot;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel fault persistence

	logic [1:0] ov_hit;
	logic [1:0] uv_hit;

	genvar ch;
	for (ch = 0; ch < 2; ch++)
	begin : g_ch
		logic dim_prev;
		logic ov_hold;
		logic uv_hold;
		logic [8:0] ov_cnt;
		logic [8:0] uv_cnt;
		wire dim_rise = s_dim[ch] & ~dim_prev;
		wire dim_fall = ~s_dim[ch] & dim_prev;
		wire uv_cond = s_uv[ch] & s_hr;

		always_ff @(posedge clk_sys_in or negedge rstn_in)
		begin
			if (!rstn_in)
			begin
				dim_prev <= 1'b0;
				ov_hold <= 1'b0;
				uv_hold <= 1'b0;
				ov_cnt <= 9'h000;
				uv_cnt <= 9'h000;
			end
			else
			begin
				dim_prev <= s_dim[ch];
				if (dim_rise)
				begin
					ov_hold <= s_ov[ch];
					uv_hold <= uv_cond;
				end
				else if (s_dim[ch])
				begin
					ov_hold <= ov_hold & s_ov[ch];
					uv_hold <= uv_hold & uv_cond;
				end
				if (hold_clr)
					ov_cnt <= 9'h000;
				else if (dim_fall)
					ov_cnt <= !ov_hold ? 9'h000 : (ov_cnt == `LDDCL_FAULT_PULSES) ? ov_cnt : ov_cnt + 9'h001;
				if (hold_clr)
					uv_cnt <= 9'h000;
				else if (dim_fall)
					uv_cnt <= !uv_hold ? 9'h000 : (uv_cnt == `LDDCL_FAULT_PULSES) ? uv_cnt : uv_cnt + 9'h001;
			end
		end

		assign ov_hit[ch] = ~hold_clr & dim_fall & ov_hold & (ov_cnt == `LDDCL_FAULT_PULSES - 9'h001);
		assign uv_hit[ch] = ~hold_clr & dim_fall & uv_hold & (uv_cnt == `LDDCL_FAULT_PULSES - 9'h001);
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault store, power-good, commands

	wire [3:0] next_code = ov_hit[0] ? `LDDCL_PAT_OV_CH1 :
		ov_hit[1] ? `LDDCL_PAT_OV_CH2 :
		uv_hit[0] ? `LDDCL_PAT_UV_CH1 : `LDDCL_PAT_UV_CH2;
	wire any_hit = |{ov_hit, uv_hit};

	logic fault_valid;
	logic [3:0] fault_code;
	logic pg_seen;
	logic line_low_sys;
	logic cmd_meta;
	logic cmd_sync;
	logic cmd_prev;
	lddcl_freq_type freq;
	logic ch1_en;
	lddcl_cmd_type lk_cmd;
	logic lk_tgl;
	wire cmd_evt = cmd_sync ^ cmd_prev;
	wire cmd_ok = cmd_evt & pg_seen & ~s_ot & ~fault_valid & s_en;

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			fault_valid <= 1'b0;
			fault_code <= 4'h0;
			pg_seen <= 1'b0;
			line_low_sys <= 1'b1;
			cmd_meta <= 1'b0;
			cmd_sync <= 1'b0;
			cmd_prev <= 1'b0;
			freq <= lddcl_freq_normal;
			ch1_en <= 1'b1;
		end
		else
		begin
			// held until cleared; enable low also masks any capture, so the clear wins
			if (any_hit)
			begin
				fault_valid <= 1'b1;
				fault_code <= next_code;
			end
			else if (!s_en)
				fault_valid <= 1'b0;
			if (s_pg)
				pg_seen <= 1'b1;
			line_low_sys <= ~(pg_seen | s_pg) | s_ot;
			cmd_meta <= lk_tgl;
			cmd_sync <= cmd_meta;
			cmd_prev <= cmd_sync;
			if (!s_en)
			begin
				freq <= lddcl_freq_normal;
				ch1_en <= 1'b1;
			end
			else if (cmd_ok)
			begin
				case (lk_cmd)
					lddcl_cmd_normal: freq <= lddcl_freq_normal;
					lddcl_cmd_down20: freq <= lddcl_freq_down20;
					lddcl_cmd_down40: freq <= lddcl_freq_down40;
					default: ch1_en <= 1'b0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain, clocked by channel-1 dimming falls

	logic [4:0] lk_meta;
	logic [4:0] lk_sync;
	logic [1:0] bit_idx;
	logic rd_low;
	logic [15:0] shift;
	wire lk_valid = lk_sync[4];
	wire [3:0] lk_code = lk_sync[3:0];
	// Line is set up by the host before the fall, so it is sampled directly
	wire [15:0] next_shift = {shift[14:0], link.diag_line};
	wire m_down20 = next_shift == `LDDCL_CMD_DOWN20_BITS;
	wire m_ch1off = next_shift[13:0] == `LDDCL_CMD_CH1OFF_BITS;
	wire m_normal = next_shift[11:0] == `LDDCL_CMD_NORMAL_BITS;
	wire m_down40 = next_shift[11:0] == `LDDCL_CMD_DOWN40_BITS;
	wire m_any = m_down20 | m_ch1off | m_normal | m_down40;

	// falling edges of the dimming input only
	always_ff @(negedge link.dim_ch1 or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lk_meta <= 5'h00;
			lk_sync <= 5'h00;
			bit_idx <= 2'h0;
			rd_low <= 1'b0;
			shift <= 16'h0000;
			lk_cmd <= lddcl_cmd_normal;
			lk_tgl <= 1'b0;
		end
		else
		begin
			lk_meta <= {fault_valid, fault_code};
			lk_sync <= lk_meta;
			bit_idx <= lk_valid ? bit_idx + 2'h1 : 2'h0;
			rd_low <= lk_valid & ~lk_code[~bit_idx];
			shift <= m_any ? 16'h0000 : next_shift;
			if (m_any)
			begin
				lk_tgl <= ~lk_tgl;
				lk_cmd <= m_down20 ? lddcl_cmd_down20 : m_ch1off ? lddcl_cmd_ch1_off :
					m_normal ? lddcl_cmd_normal : lddcl_cmd_down40;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin and outputs

	assign link.dev_diag_out = 1'b0;
	assign link.dev_diag_oe = line_low_sys | rd_low;
	assign switch_freq_out = freq;
	assign sink_en_ch1_out = ch1_en;
	assign power_good_out = pg_seen;
	assign over_temp_out = s_ot;
	assign fault_valid_out = fault_valid;
	assign fault_code_out = fault_code;

endmodule

// [logic/lddcl_host_end.sv]
`include "lddcl_params.svh"

module lddcl_host_end
	import lddcl_pkg::*;
(
	// System
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Link
	lddcl_if.host link,
	// Command request
	input wire logic cmd_valid_in,
	input wire lddcl_cmd_type cmd_sel_in,
	output logic cmd_ready_out,
	// Clear request
	input wire logic clear_req_in,
	input wire logic auto_clear_in,
	// Dimming and status
	input wire logic dim_ch2_in,
	output logic line_level_out,
	output logic pat_valid_out,
	output logic [3:0] pat_code_out
);

	localparam logic [1:0] EN_CYC = 2'(`LDDCL_EN_PULSE_CYC);
	localparam logic [4:0] DIM_LAST = 5'(2 * `LDDCL_DIM_HALF - 1);

	////////////////////////////////////////////////////////////////////////////
	// Link clock divider

	logic [4:0] div_cnt;
	logic dim_ch1;
	logic dim_ch2;
	wire rise_evt = div_cnt == DIM_LAST;

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			div_cnt <= 5'h00;
			dim_ch1 <= 1'b0;
			dim_ch2 <= 1'b0;
		end
		else
		begin
			div_cnt <= rise_evt ? 5'h00 : div_cnt + 5'h01;
			// falling edge is the latch point
			dim_ch1 <= div_cnt < `LDDCL_DIM_HALF - 5'h01 || rise_evt;
			dim_ch2 <= dim_ch2_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command transmit

	logic [15:0] tx_shift;
	logic [4:0] tx_left;
	logic drive_low;
	logic [15:0] cmd_bits;
	logic [4:0] cmd_len;

	always_comb
	begin
		case (cmd_sel_in)
			lddcl_cmd_normal:
			begin
				cmd_bits = {`LDDCL_CMD_NORMAL_BITS, 4'h0};
				cmd_len = `LDDCL_CMD_NORMAL_LEN;
			end
			lddcl_cmd_down20:
			begin
				cmd_bits = `LDDCL_CMD_DOWN20_BITS;
				cmd_len = `LDDCL_CMD_DOWN20_LEN;
			end
			lddcl_cmd_down40:
			begin
				cmd_bits = {`LDDCL_CMD_DOWN40_BITS, 4'h0};
				cmd_len = `LDDCL_CMD_DOWN40_LEN;
			end
			default:
			begin
				cmd_bits = {`LDDCL_CMD_CH1OFF_BITS, 2'h0};
				cmd_len = `LDDCL_CMD_CH1OFF_LEN;
			end
		endcase
	end

	assign cmd_ready_out = tx_left == 5'h00;
	wire cmd_take = cmd_valid_in & cmd_ready_out;

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tx_shift <= 16'h0000;
			tx_left <= 5'h00;
			drive_low <= 1'b0;
		end
		else
		begin
			// bit changes half a period before the latch
			if (rise_evt)
				drive_low <= (tx_left != 5'h00) & ~tx_shift[15];
			// A load on a rise never drops the bit already latched
			if (cmd_take)
			begin
				tx_shift <= cmd_bits;
				tx_left <= cmd_len;
			end
			else if (rise_evt && tx_left != 5'h00)
			begin
				tx_shift <= {tx_shift[14:0], 1'b0};
				tx_left <= tx_left - 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pattern receive and enable pulse

	logic line_meta;
	logic line_sync;
	logic [4:0] rx;
	logic [1:0] en_cnt;
	wire [4:0] next_rx = {rx[3:0], line_sync};
	// Pattern starts 0, ends 1, after a 1; a line held low never qualifies
	wire pat_seen = rise_evt & ~drive_low & cmd_ready_out & next_rx[4] & ~next_rx[3] & next_rx[0];

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			line_meta <= 1'b0;
			line_sync <= 1'b0;
			rx <= 5'h00;
			pat_valid_out <= 1'b0;
			pat_code_out <= 4'h0;
			en_cnt <= 2'h0;
		end
		else
		begin
			line_meta <= link.diag_line;
			line_sync <= line_meta;
			// sampled at end of low phase
			// Own command bits are flushed so their tail never reads as a pattern
			if (rise_evt)
				rx <= cmd_ready_out ? next_rx : 5'h00;
			pat_valid_out <= pat_seen;
			if (pat_seen)
				pat_code_out <= next_rx[3:0];
			if (clear_req_in || (pat_seen && auto_clear_in))
				en_cnt <= EN_CYC;
			else if (en_cnt != 2'h0)
				en_cnt <= en_cnt - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins

	assign link.pullup_en = 1'b1;
	assign link.host_diag_out = 1'b0;
	assign link.host_diag_oe = drive_low;
	assign link.dim_ch1 = dim_ch1;
	assign link.dim_ch2 = dim_ch2;
	assign link.en = en_cnt == 2'h0;
	assign line_level_out = line_sync;

endmodule

// [dv/lddcl_sva.sv]
module lddcl_sva
	import lddcl_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Link signals
	input wire logic dim_ch1,
	input wire logic en,
	input wire logic dev_diag_oe,
	// Device status
	input wire lddcl_freq_type switch_freq_out,
	input wire logic sink_en_ch1_out,
	input wire logic power_good_out,
	input wire logic over_temp_out,
	input wire logic fault_valid_out
);
	default clocking sys_cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);

	pg_hold_low_a:
		assert property (!power_good_out |-> dev_diag_oe)
		else $error("line released before power good");
	pg_latch_a:
		assert property (power_good_out |=> power_good_out)
		else $error("power good dropped");
	ot_line_low_a:
		assert property (over_temp_out && $past(over_temp_out) |-> dev_diag_oe)
		else $error("line not low in over temperature");
	// Margins keep clear of the power good and over temperature hand-over
	quiet_link_a:
		assert property (power_good_out && $past(power_good_out, 4) && !over_temp_out && !$past(over_temp_out)
			&& !$past(over_temp_out, 2) && $stable(dim_ch1) |-> $stable(dev_diag_oe))
		else $error("line moved without a dimming edge");
	en_restore_a:
		assert property ($fell(en) |-> ##[1:6] (switch_freq_out == lddcl_freq_normal && sink_en_ch1_out))
		else $error("enable low kept settings");
	en_clear_a:
		assert property ($fell(en) |-> ##[1:6] !fault_valid_out)
		else $error("enable low kept fault");
	early_cmd_a:
		assert property (!power_good_out |-> switch_freq_out == lddcl_freq_normal && sink_en_ch1_out)
		else $error("command before power good");
	fault_blocks_a:
		assert property (fault_valid_out && $past(fault_valid_out, 5)
			|-> $stable(switch_freq_out) && $stable(sink_en_ch1_out))
		else $error("command taken with fault stored");
	ot_blocks_a:
		assert property (over_temp_out && $past(over_temp_out, 5) |-> $stable(switch_freq_out))
		else $error("command taken in over temperature");
	fault_hold_a:
		assert property (fault_valid_out && en && $past(en) && $past(en, 2) && $past(en, 3) |=> fault_valid_out)
		else $error("stored fault lost");
endmodule

// [dv/led_driver_diag_diag_line_link_tb.sv]
module led_driver_diag_diag_line_link_tb
	import lddcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cmd_valid = 1'b0;
	lddcl_cmd_type cmd_sel = lddcl_cmd_normal;
	logic clear_req = 1'b0;
	logic auto_clear = 1'b0;
	logic dim2 = 1'b0;
	logic pg = 1'b0;
	logic ot = 1'b0;
	logic hmax = 1'b0;
	logic [1:0] ov = 2'h0;
	logic [1:0] uv = 2'h0;
	lddcl_freq_type freq;
	logic sink1;
	logic pg_out;
	logic ot_out;
	logic fv;
	logic ready;
	logic line;
	logic pv;
	logic [3:0] fcode;
	logic [3:0] pcode;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	lddcl_cmd_type cmds [6] = '{lddcl_cmd_down20, lddcl_cmd_down40, lddcl_cmd_normal, lddcl_cmd_down40,
		lddcl_cmd_ch1_off, lddcl_cmd_down20};
	lddcl_freq_type fexp [6] = '{lddcl_freq_down20, lddcl_freq_down40, lddcl_freq_normal, lddcl_freq_down40,
		lddcl_freq_down40, lddcl_freq_down20};
	logic [5:0] sexp = 6'h0F;
	logic [1:0] ovt [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
	logic [1:0] uvt [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
	logic [3:0] codes [4] = '{4'h1, 4'h3, 4'h5, 4'h7};

	always #50 clk_sys_in = ~clk_sys_in;

	lddcl_if lddcl_if_i ();
	lddcl_dev_end lddcl_dev_end_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(lddcl_if_i.dev),
		.pg_cmp_in(pg), .ot_cmp_in(ot), .ov_cmp_in(ov), .uv_cmp_in(uv), .headroom_max_in(hmax),
		.switch_freq_out(freq), .sink_en_ch1_out(sink1), .power_good_out(pg_out), .over_temp_out(ot_out),
		.fault_valid_out(fv), .fault_code_out(fcode));
	lddcl_host_end lddcl_host_end_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(lddcl_if_i.host),
		.cmd_valid_in(cmd_valid), .cmd_sel_in(cmd_sel), .cmd_ready_out(ready), .clear_req_in(clear_req),
		.auto_clear_in(auto_clear), .dim_ch2_in(dim2), .line_level_out(line), .pat_valid_out(pv),
		.pat_code_out(pcode));
	lddcl_sva lddcl_sva_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .dim_ch1(lddcl_if_i.dim_ch1),
		.en(lddcl_if_i.en), .dev_diag_oe(lddcl_if_i.dev_diag_oe), .switch_freq_out(freq),
		.sink_en_ch1_out(sink1), .power_good_out(pg_out), .over_temp_out(ot_out), .fault_valid_out(fv));

	////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	task automatic send_cmd(input lddcl_cmd_type c);
		int n = 0;
		cmd_valid <= 1'b1;
		cmd_sel <= c;
		wait_cyc(2);
		cmd_valid <= 1'b0;
		while (ready !== 1'b1 && n < 400)
		begin
			n++;
			wait_cyc(1);
		end
		// Last bit lands a half dimming period after ready returns
		wait_cyc(20);
	endtask

	task automatic do_clear();
		clear_req <= 1'b1;
		wait_cyc(1);
		clear_req <= 1'b0;
		wait_cyc(12);
	endtask

	task automatic read_pat(input logic [3:0] exp);
		int n = 0;
		wait_cyc(1);
		while (pv !== 1'b1 && n < 300)
		begin
			n++;
			wait_cyc(1);
		end
		check(4'(pv), 4'h1, "pattern seen");
		check(pcode, exp, "pattern");
	endtask

	////////////////////////////////////////
	// Cycle count, channel-2 dimming and hang guard
	always @(posedge clk_sys_in)
	begin
		cycles <= cycles + 1;
		dim2 <= cycles[3];
		if (cycles == 60000)
		begin
			fail_count++;
			$display("BAD t=%0t timeout", $time);
			summarize();
		end
	end

	initial
	begin
		int n;
		wait_cyc(4);
		rstn_in <= 1'b1;
		wait_cyc(3);
		check(4'(freq), 4'(lddcl_freq_normal), "freq");
		check(4'(sink1), 4'h1, "sink1");
		check(4'(line), 4'h0, "line");
		send_cmd(lddcl_cmd_ch1_off);
		check(4'(sink1), 4'h1, "early cmd");
		pg <= 1'b1;
		wait_cyc(10);
		check(4'(line), 4'h1, "power good");
		$display("done reset and power good");
		for (int i = 0; i < 6; i++)
		begin
			send_cmd(cmds[i]);
			check(4'(freq), 4'(fexp[i]), "freq");
			check(4'(sink1), 4'(sexp[i]), "sink1");
		end
		do_clear();
		check(4'(freq), 4'(lddcl_freq_normal), "freq restore");
		check(4'(sink1), 4'h1, "sink restore");
		$display("done commands");
		ot <= 1'b1;
		wait_cyc(10);
		check(4'(line), 4'h0, "ot line");
		send_cmd(lddcl_cmd_down40);
		check(4'(freq), 4'(lddcl_freq_normal), "ot cmd");
		ot <= 1'b0;
		wait_cyc(10);
		check(4'(line), 4'h1, "ot end");
		$display("done over temperature");
		// Low sink without headroom at max is no fault
		uv <= 2'h3;
		wait_cyc(8320);
		check(4'(fv), 4'h0, "uv no headroom");
		hmax <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			ov <= ovt[i];
			uv <= uvt[i];
			wait_cyc(8000);
			check(4'(fv), 4'h0, "early fault");
			n = 0;
			while (fv !== 1'b1 && n < 400)
			begin
				n++;
				wait_cyc(1);
			end
			check(fcode, codes[i], "fault code");
			ov <= 2'h0;
			uv <= 2'h0;
			read_pat(codes[i]);
			read_pat(codes[i]);
			check(4'(sink1), 4'h1, "no shutdown");
			if (i == 0)
			begin
				send_cmd(lddcl_cmd_down20);
				check(4'(freq), 4'(lddcl_freq_normal), "fault cmd");
				ot <= 1'b1;
				wait_cyc(10);
				check(4'(line), 4'h0, "ot masks");
				ot <= 1'b0;
				read_pat(codes[i]);
				read_pat(codes[i]);
				check(4'(fv), 4'h1, "ot keeps");
			end
			if (i == 3)
			begin
				// Host clears by itself once it has read the pattern
				auto_clear <= 1'b1;
				read_pat(codes[i]);
				auto_clear <= 1'b0;
				wait_cyc(12);
				check(4'(fv), 4'h0, "auto clear");
			end
			do_clear();
			check(4'(fv), 4'h0, "clear");
			wait_cyc(200);
			check(4'(fv), 4'h0, "stays clear");
		end
		$display("done faults");
		summarize();
	end
endmodule
